//--- include/fpes_cfg.svh
// Constants for the flash status polling controller
`ifndef FPES_CFG_SVH
`define FPES_CFG_SVH
`define FPES_OFF_CTRL        8'h00
`define FPES_OFF_STATUS      8'h04
`define FPES_OFF_RESULT      8'h08
`define FPES_BIT_IDLE        7
`define FPES_BIT_ERASE_PAUSE 6
`define FPES_BIT_ERASE_FAIL  5
`define FPES_BIT_PROG_FAIL   4
`define FPES_BIT_PROGRAM_ERASE_ENABLE_INPUT_FAULT  3
`define FPES_BIT_PROG_PAUSE  2
`define FPES_BIT_PROT_HIT    1
`define FPES_SPARE_MASK      8'hFE
`define FPES_CMD_READ_STATUS 8'h70
`define FPES_CMD_CLEAR       8'h50
`define FPES_STATUS_IDLE     8'h80
`define FPES_HSIZE_WORD      3'h2
// Extra read strobe cycles so the input synchroniser catches settled data
`define FPES_SYNC_EXTRA      8'h02
`define FPES_STROBE_NS       100
`define FPES_CLK_NS          20
`define FPES_STROBE_CYC      ((`FPES_STROBE_NS + `FPES_CLK_NS - 1) / `FPES_CLK_NS)
`endif

//--- include/fpes_pkg.sv
// Types for the flash status polling controller
package fpes_pkg;
  typedef enum logic [2:0] {
    FPES_IDLE,
    FPES_WR_CMD,
    FPES_WR_GAP,
    FPES_RD_PULSE,
    FPES_RD_GAP,
    FPES_DONE
  } fpes_state_e;
  typedef logic [7:0] fpes_byte_t;
endpackage

//--- testbench/fpes_flash_model.sv
// Flash status register model for the host bench
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model (
  input  wire logic       i_cs_n,
  input  wire logic       i_oe_n,
  input  wire logic       i_we_n,
  input  wire logic [7:0] i_data,
  input  wire logic [7:0] i_fault,
  input  wire logic [3:0] i_busy,
  output logic      [7:0] o_data
);
  logic [7:0] sr   = 8'h80; // Power-up state, as after a reset
  logic [3:0] left = 4'h0;
  logic [7:0] drv;
  always @(posedge i_we_n)
    if (!i_cs_n && i_data == 8'h50)
      sr = sr & 8'hC5;
    else if (!i_cs_n)
    begin
      // Sticky flags kept, pause bits fresh
      sr = (sr & 8'h3A) | i_fault | 8'h80;
      left = i_busy;
    end
  // Each output enable toggle refreshes status
  always @(negedge i_oe_n)
    if (left != 4'h0)
      left = left - 4'h1;
  // Busy floats the low bits; spare bit set to catch a missing mask
  // Released bus shows the inverse, so a late sample is caught
  always_comb
  begin
    if (left != 4'h0)
      drv = {1'b0, ~sr[6:0]};
    else
      drv = sr | 8'h01;
    o_data = (i_cs_n || i_oe_n) ? ~drv : drv;
  end
endmodule
`default_nettype wire

//--- testbench/fpes_host_props.sv
// Pin and bus timing checker for the flash status host
`timescale 1ns/1ps
`default_nettype none
module fpes_host_props (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       o_hreadyout,
  input  wire logic       o_hresp,
  input  wire logic [7:0] o_low_data_byte,
  input  wire logic       o_low_data_byte_oe,
  input  wire logic       o_chip_select_n,
  input  wire logic       o_output_enable_n,
  input  wire logic       o_write_enable_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_cmd;
    !o_write_enable_n [*5] ##1 o_write_enable_n;
  endsequence
  sequence s_rd;
    !o_output_enable_n [*7] ##1 o_output_enable_n;
  endsequence
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus wait or error");
  cmd_width_a: assert property ($fell(o_write_enable_n) |-> s_cmd)
    else $error("command strobe width");
  read_width_a: assert property ($fell(o_output_enable_n) |-> s_rd)
    else $error("read strobe width");
  cmd_code_a: assert property (!o_write_enable_n |-> o_low_data_byte_oe
    && (o_low_data_byte == 8'h70 || o_low_data_byte == 8'h50)) else $error("command byte");
  no_fight_a: assert property (!o_output_enable_n |-> !o_low_data_byte_oe)
    else $error("host drives during read");
  strobe_sel_a: assert property (!o_output_enable_n |-> !o_chip_select_n)
    else $error("read without select");
  cmd_gap_a: assert property ($rose(o_write_enable_n) |-> o_output_enable_n [*5])
    else $error("read too soon after command");
  refresh_a: assert property ($rose(o_output_enable_n) |->
    o_output_enable_n [*5] ##1 (!o_output_enable_n || o_chip_select_n)) else $error("poll");
endmodule
bind fpes_host fpes_host_props u_props (.i_clk(i_clk), .i_resetn(i_resetn),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_low_data_byte(o_low_data_byte),
  .o_low_data_byte_oe(o_low_data_byte_oe), .o_chip_select_n(o_chip_select_n),
  .o_output_enable_n(o_output_enable_n), .o_write_enable_n(o_write_enable_n));
`default_nettype wire

//--- testbench/fpes_host_tb_top.sv
// Self-checking bench for the flash status host
`timescale 1ns/1ps
`default_nettype none
module fpes_host_tb_top;
  logic        i_clk;
  logic        i_resetn = 1'b0;
  logic        hsel     = 1'b0;
  logic        hwrite   = 1'b0;
  logic [1:0]  htrans   = 2'h0;
  logic [31:0] haddr    = 32'h0;
  logic [31:0] hwdata   = 32'h0;
  logic [7:0]  fault    = 8'h00;
  logic [3:0]  busy     = 4'h0;
  logic [31:0] seed     = 32'hC956;
  logic [31:0] hrdata;
  logic [31:0] seen;
  logic        hready;
  logic        hresp;
  logic [7:0]  dout;
  logic [7:0]  mdata;
  logic        doe;
  logic        cs_n;
  logic        oe_n;
  logic        we_n;
  logic [31:0] exp_q[$];
  int          mismatches  = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  event        got;
  wire  [7:0]  din = doe ? dout : mdata;
  fpes_host #(.STROBE_CYC(5)) uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_low_data_byte(din), .o_low_data_byte(dout),
    .o_low_data_byte_oe(doe), .o_chip_select_n(cs_n), .o_output_enable_n(oe_n),
    .o_write_enable_n(we_n));
  fpes_flash_model u_flash (.i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_data(din),
    .i_fault(fault), .i_busy(busy), .o_data(mdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, seen);
    -> got;
  endtask
  task automatic run(input logic [7:0] f, input logic [3:0] b, input logic [31:0] c,
                     input logic [7:0] e);
    logic [31:0] r;
    fault <= f;
    busy <= b;
    bus(1'b1, 8'h00, c, r);
    repeat (3) @(posedge i_clk);
    r = 32'h0;
    for (int i = 0; i < 300 && r[1:0] !== 2'b10; i++)
      bus(1'b0, 8'h04, 32'h0, r);
    check("status", {26'h0, r[5:0]},
          {26'h0, |(e & 8'h3A), e[1], |(e & 8'h3A), 3'b010});
    rd(8'h08, {24'h0, e});
    $display("op %h fault %h done", c[7:0], f);
  endtask
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(got) check("read data", seen, exp_q.pop_front());
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    run(8'h00, 4'h4, 32'h1, 8'h80);
    run(8'h30, 4'h2, 32'h1, 8'hB0);
    run(8'h00, 4'h0, 32'h1, 8'hB0);
    run(8'h00, 4'h0, 32'h2, 8'h80);
    repeat (4)
    begin
      seed = lfsr(seed);
      run(seed[7:0] & 8'h7E, {2'h0, seed[9:8]}, 32'h1,
          8'h80 | seed[7:0] & 8'h7E);
      run(8'h00, 4'h0, 32'h2, 8'h80);
    end
    rd(8'h0C, 32'h0);
    $display("unmapped read done");
    // Let the queue checker take the last note first
    @(posedge i_clk);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/fpes_host.sv
// Host controller that polls and clears a flash status register over AHB-Lite
// How it works
// - Each poll toggles output enable so the device refreshes status.
// - Other bits are ignored until idle, then checked for errors.
// - Software is told errors are pending before issuing commands.
// - Spare bit is masked out of every captured value.
`timescale 1ns/1ps
`default_nettype none
`include "fpes_cfg.svh"
module fpes_host #(
  parameter int STROBE_CYC = `FPES_STROBE_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic [7:0]  i_low_data_byte,
  output logic      [7:0]  o_low_data_byte,
  output logic             o_low_data_byte_oe,
  output logic             o_chip_select_n,
  output logic             o_output_enable_n,
  output logic             o_write_enable_n
);
  // Read strobe adds the sync cycles to an 8-bit counter
  if (STROBE_CYC < 1 || STROBE_CYC > 253)
  begin : g_bad_strobe
    $error("STROBE_CYC out of range");
  end

  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  logic [7:0] din_s1_q;
  logic [7:0] din_s2_q;
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end
    else
    begin
      din_s1_q <= i_low_data_byte;
      din_s2_q <= din_s1_q;
    end
  end

  // AHB address phase capture
  logic        ap_wr_q;
  logic        ap_wr_d;
  logic        ap_rd_d;
  logic [7:0]  ap_addr_q;
  logic [7:0]  ap_addr_d;
  wire logic   ap_valid = i_hsel && i_hready && i_htrans[1] && (i_hsize == `FPES_HSIZE_WORD);

  fpes_pkg::fpes_state_e state_q;
  fpes_pkg::fpes_state_e state_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic        clear_q;
  logic        clear_d;
  fpes_pkg::fpes_byte_t result_q;
  fpes_pkg::fpes_byte_t result_d;
  logic        done_q;
  logic        done_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  function automatic logic [1:0] fpes_decode(input logic [7:0] a);
    if (a == `FPES_OFF_CTRL)
      fpes_decode = 2'h1;
    else if (a == `FPES_OFF_STATUS)
      fpes_decode = 2'h2;
    else if (a == `FPES_OFF_RESULT)
      fpes_decode = 2'h3;
    else
      fpes_decode = 2'h0;
  endfunction

  wire logic busy   = (state_q != fpes_pkg::FPES_IDLE) && (state_q != fpes_pkg::FPES_DONE);
  wire logic [7:0] r = result_q;
  wire logic errs   = r[`FPES_BIT_ERASE_FAIL] | r[`FPES_BIT_PROG_FAIL] |
                      r[`FPES_BIT_PROGRAM_ERASE_ENABLE_INPUT_FAULT] | r[`FPES_BIT_PROT_HIT];

  always_comb
  begin
    ap_wr_d   = ap_valid && i_hwrite;
    ap_rd_d   = ap_valid && !i_hwrite;
    ap_addr_d = ap_valid ? i_haddr[7:0] : ap_addr_q;
    state_d   = state_q;
    cnt_d     = cnt_q;
    clear_d   = clear_q;
    result_d  = result_q;
    done_d    = done_q;
    rdata_d   = 32'h0000_0000;
    if (ap_rd_d)
    begin
      case (fpes_decode(i_haddr[7:0]))
        2'h2:    rdata_d = {26'h0, errs && done_q,
                            r[`FPES_BIT_PROT_HIT] && done_q, errs && done_q, 1'b0, done_q, busy};
        2'h3:    rdata_d = {24'h0, result_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    // Write to control starts a poll (bit0) or a clear (bit1)
    if (ap_wr_q && fpes_decode(ap_addr_q) == 2'h1 && !busy)
    begin
      clear_d = i_hwdata[1];
      if (i_hwdata[0] || i_hwdata[1])
      begin
        state_d = fpes_pkg::FPES_WR_CMD;
        cnt_d   = 8'(STROBE_CYC);
        done_d  = 1'b0;
      end
    end
    case (state_q)
      fpes_pkg::FPES_WR_CMD:
      begin
        if (cnt_q == 8'h01)
        begin
          state_d = fpes_pkg::FPES_WR_GAP;
          cnt_d   = 8'(STROBE_CYC);
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      fpes_pkg::FPES_WR_GAP:
      begin
        if (cnt_q == 8'h01)
        begin
          state_d = clear_q ? fpes_pkg::FPES_DONE : fpes_pkg::FPES_RD_PULSE;
          cnt_d   = 8'(STROBE_CYC) + `FPES_SYNC_EXTRA;
          if (clear_q)
          begin
            result_d = `FPES_STATUS_IDLE;
            done_d   = 1'b1;
          end
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      fpes_pkg::FPES_RD_PULSE:
      begin
        if (cnt_q == 8'h01)
        begin
          // Sample after sync delay; mask spare bit
          result_d = din_s2_q & `FPES_SPARE_MASK;
          state_d  = fpes_pkg::FPES_RD_GAP;
          cnt_d    = 8'(STROBE_CYC);
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      fpes_pkg::FPES_RD_GAP:
      begin
        if (cnt_q == 8'h01)
        begin
          // Other bits are meaningless while busy, keep toggling OE
          if (result_q[`FPES_BIT_IDLE])
          begin
            state_d = fpes_pkg::FPES_DONE;
            done_d  = 1'b1;
          end
          else
          begin
            state_d = fpes_pkg::FPES_RD_PULSE;
            cnt_d   = 8'(STROBE_CYC) + `FPES_SYNC_EXTRA;
          end
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      state_q   <= fpes_pkg::FPES_IDLE;
      cnt_q     <= 8'h00;
      clear_q   <= 1'b0;
      result_q  <= 8'h00;
      done_q    <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      ap_wr_q   <= ap_wr_d;
      ap_addr_q <= ap_addr_d;
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      clear_q   <= clear_d;
      result_q  <= result_d;
      done_q    <= done_d;
      rdata_q   <= rdata_d;
    end
  end

  // Pins: address is don't-care, status returns at any address
  assign o_chip_select_n    = !busy;
  assign o_write_enable_n   = state_q != fpes_pkg::FPES_WR_CMD;
  assign o_low_data_byte_oe = (state_q == fpes_pkg::FPES_WR_CMD) ||
                              (state_q == fpes_pkg::FPES_WR_GAP);
  assign o_low_data_byte    = clear_q ? `FPES_CMD_CLEAR : `FPES_CMD_READ_STATUS;
  assign o_output_enable_n  = state_q != fpes_pkg::FPES_RD_PULSE;
  assign o_hrdata           = rdata_q;
  assign o_hreadyout        = 1'b1;
  assign o_hresp            = 1'b0;
endmodule
`default_nettype wire
